// >>> common/pbm_pkg.sv
package pbm_pkg;

    // ------------------------------------------------------------------
    // Bus commands and widths
    // ------------------------------------------------------------------
    localparam int          PBM_AW        = 32;
    localparam int          PBM_DW        = 64;
    localparam logic [3:0]  PBM_CMD_SPCYC = 4'h1;
    localparam logic [3:0]  PBM_CMD_DAC   = 4'hd;
    localparam logic [3:0]  PBM_BE_ALL    = 4'h0;
    localparam int          PBM_LO_W      = 32;

    // Cycles the master waits for a device select before giving up.
    localparam int          PBM_DEVSEL_TO = 5;
    // Cycles the master waits for a target ready in a data phase.
    localparam int          PBM_TRDY_TO   = 16;

    // ------------------------------------------------------------------
    // User command and answer carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        write;
        logic        wide;
        logic        dac;
        logic        locked;
        logic [3:0]  cmd;
        logic [63:0] addr;
        logic [7:0]  len;
    } pbm_req_s;

    typedef struct packed {
        logic [63:0] data;
        logic [7:0]  be_n;
    } pbm_word_s;

    typedef struct packed {
        logic        done;
        logic        master_abort;
        logic        target_stop;
        logic        perr;
        logic        serr;
        logic        got64;
    } pbm_status_s;

    typedef enum logic [2:0] {
        PBM_IDLE  = 3'b000,
        PBM_REQ   = 3'b001,
        PBM_ADDR  = 3'b010,
        PBM_ADDR2 = 3'b011,
        PBM_WAITD = 3'b100,
        PBM_DATA  = 3'b101,
        PBM_TURN  = 3'b110
    } pbm_state_e;

endpackage : pbm_pkg

// >>> core/pbm_parity.sv
`timescale 1ns/1ps

// Even parity over one 32-bit lane and its four command/enable lines.
module pbm_parity
    import pbm_pkg::*;
(
    input  wire logic [31:0] ad,   // Address/data lane.
    input  wire logic [3:0]  cbe,  // Command or byte enables of the lane.
    output logic             par   // Even parity bit.
);

    // ------------------------------------------------------------------
    // Parity
    // ------------------------------------------------------------------
    // The XOR makes the count of ones on lane, enables and parity even.
    assign par = ^{ad, cbe};

endmodule : pbm_parity

// >>> core/pbm_master.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Overview of operation
// - One address phase (two for DAC), then data phases.
// - Address on low lines; byte zero lowest.
// - Master drives command, then active-low enables.
// - Enables held across the whole data phase.
// - Master drives REQ64 timed like FRAME.
// - Upper half read only when REQ64 and ACK64; driven on REQ64 alone.
// - DAC puts upper address and command up; the upper address lane is driven only for wide requests.
// - FRAME held until the final data phase.
// - IRDY only with data or room.
// - PAR even over low lane and enables.
// - PAR64 even over upper lane and enables.
// - Own request and grant per master.
// - Locked addresses excluded for other transactions; the master only drives LOCK low during a locked request.
// ------------------------------------------------------------------
module pbm_master
    import pbm_pkg::*;
#(
    parameter int DEVSEL_TO = PBM_DEVSEL_TO, // Master abort timeout in cycles.
    parameter int TRDY_TO   = PBM_TRDY_TO    // Data phase timeout in cycles.
) (
    input  wire logic        clk,          // Bus clock, 40 MHz.
    input  wire logic        rst,          // Synchronous reset, active high.
    input  wire logic        req_valid,    // User command valid.
    output logic             req_ready,    // Command accepted.
    input  wire pbm_req_s    req,          // Command.
    input  wire pbm_word_s   wdata,        // Write word for the current phase.
    output logic             wdata_ready,  // Write word consumed this cycle.
    output pbm_word_s        rdata,        // Read word.
    output logic             rdata_valid,  // Read word pulse.
    output pbm_status_s      status,       // End-of-transaction status.
    output logic             irq_n_any,    // Any interrupt line low, synced.
    output logic             snoop_dirty,  // Snoop hit a modified line, synced.
    output logic             snoop_clean,  // Snoop clean, synced.
    output logic             req64_strap,  // 64-bit strap sampled after reset.
    output logic             req_n,        // Bus request to arbiter.
    input  wire logic        gnt_n,        // Bus grant from arbiter.
    input  wire logic [63:0] ad_i,         // AD pins in.
    output logic [63:0]      ad_o,         // AD pins out.
    output logic             ad_oe,        // AD low lane drive.
    output logic             ad_hi_oe,     // AD high lane drive.
    output logic [7:0]       cbe_n_o,      // Command/enables out.
    output logic             cbe_oe,       // Command/enables drive.
    input  wire logic        par_i,        // PAR in.
    input  wire logic        par64_i,      // PAR64 in.
    output logic             par_o,        // PAR out.
    output logic             par64_o,      // PAR64 out.
    output logic             par_oe,       // PAR and PAR64 drive.
    output logic             frame_n_o,    // FRAME out.
    output logic             req64_n_o,    // REQ64 out.
    output logic             ctl_oe,       // FRAME, REQ64, IRDY drive.
    output logic             irdy_n_o,     // IRDY out.
    output logic             lock_n_o,     // LOCK out.
    output logic             lock_oe,      // LOCK drive.
    input  wire logic        req64_n_i,    // REQ64 pin in, for reset strap.
    input  wire logic        devsel_n_i,   // DEVSEL in.
    input  wire logic        ack64_n_i,    // ACK64 in.
    input  wire logic        trdy_n_i,     // TRDY in.
    input  wire logic        stop_n_i,     // STOP in.
    input  wire logic        perr_n_i,     // PERR in.
    input  wire logic        serr_n_i,     // SERR in.
    input  wire logic [3:0]  int_n_i,      // INTA..INTD in.
    input  wire logic        sdone_i,      // Snoop done in.
    input  wire logic        sbo_n_i,      // Snoop backoff in.
    output logic             idsel_o       // Configuration chip select.
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    localparam int NSY = 14;
    logic [NSY-1:0] raw_in, sy1_q, sy2_q;
    assign raw_in = {gnt_n, devsel_n_i, ack64_n_i, trdy_n_i, stop_n_i, perr_n_i,
                     serr_n_i, int_n_i, sdone_i, sbo_n_i, req64_n_i};

    // Two flops per pin before any logic reads it.
    always_ff @(posedge clk) begin
        if (rst) begin
            sy1_q <= '1;
            sy2_q <= '1;
        end else begin
            sy1_q <= raw_in;
            sy2_q <= sy1_q;
        end
    end

    logic gnt_s, devsel_s, ack64_s, trdy_s, stop_s, perr_s, serr_s;
    logic sdone_s, sbo_s, req64_s;
    logic [3:0] int_s;
    assign {gnt_s, devsel_s, ack64_s, trdy_s, stop_s, perr_s, serr_s, int_s,
            sdone_s, sbo_s, req64_s} = ~sy2_q ^ {10'h000, 4'h4};

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    pbm_state_e  state_q;
    pbm_req_s    cur_q;
    logic [7:0]  left_q;
    logic [4:0]  tmo_q;
    logic        wide_q;
    logic [2:0]  strap_sh_q;

    // The last data phase is the one where FRAME is released.
    logic last_ph;
    assign last_ph = (left_q == 8'h01);
    logic xfer;
    assign xfer = (state_q == PBM_DATA) && trdy_s;

    assign req_ready   = (state_q == PBM_IDLE) && !rst;
    assign wdata_ready = xfer && cur_q.write;

    // Main transaction sequencer.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= PBM_IDLE;
            cur_q   <= '0;
            left_q  <= 8'h00;
            tmo_q   <= 5'h00;
            wide_q  <= 1'b0;
        end else begin
            case (state_q)
                PBM_IDLE: if (req_valid) begin
                    cur_q   <= req;
                    left_q  <= (req.len == 8'h00) ? 8'h01 : req.len;
                    state_q <= PBM_REQ;
                end
                PBM_REQ: if (gnt_s) begin
                    state_q <= PBM_ADDR;
                end
                PBM_ADDR: begin
                    tmo_q   <= 5'h00;
                    state_q <= cur_q.dac ? PBM_ADDR2 : PBM_WAITD;
                end
                PBM_ADDR2: state_q <= PBM_WAITD;
                PBM_WAITD: begin
                    tmo_q <= tmo_q + 5'h01;
                    if (devsel_s) begin
                        wide_q  <= cur_q.wide && ack64_s;
                        tmo_q   <= 5'h00;
                        state_q <= PBM_DATA;
                    end else if (tmo_q == 5'(DEVSEL_TO)) begin
                        state_q <= PBM_TURN;
                    end
                end
                PBM_DATA: begin
                    tmo_q <= tmo_q + 5'h01;
                    if (xfer) begin
                        tmo_q  <= 5'h00;
                        left_q <= left_q - 8'h01;
                        cur_q.addr <= cur_q.addr + (wide_q ? 64'h8 : 64'h4);
                    end
                    if ((xfer && last_ph) || stop_s || !devsel_s
                        || tmo_q == 5'(TRDY_TO)) begin
                        state_q <= PBM_TURN;
                    end
                end
                PBM_TURN: state_q <= PBM_IDLE;
                default:  state_q <= PBM_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    logic [31:0] lo_ad, hi_ad;
    logic [3:0]  lo_cbe, hi_cbe;
    logic        par_lo, par_hi;

    // Address and command per phase; enables during data.
    always_comb begin
        lo_ad  = cur_q.addr[31:0];
        hi_ad  = cur_q.addr[63:32];
        lo_cbe = cur_q.cmd;
        hi_cbe = cur_q.cmd;
        if (state_q == PBM_ADDR && cur_q.dac) begin
            lo_cbe = PBM_CMD_DAC;
        end else if (state_q == PBM_ADDR2) begin
            lo_ad = cur_q.addr[63:32];
        end else if (state_q == PBM_WAITD || state_q == PBM_DATA) begin
            lo_ad  = wdata.data[31:0];
            hi_ad  = wdata.data[63:32];
            lo_cbe = wdata.be_n[3:0];
            hi_cbe = wdata.be_n[7:4];
        end
    end

    // Parity is taken over the lanes as they stand on the pins, so it trails them by a clock.
    pbm_parity u_par_lo (.ad(ad_o[31:0]), .cbe(cbe_n_o[3:0]), .par(par_lo));
    pbm_parity u_par_hi (.ad(ad_o[63:32]), .cbe(cbe_n_o[7:4]), .par(par_hi));

    logic active, addr_ph, drv_data;
    assign active   = (state_q == PBM_ADDR) || (state_q == PBM_ADDR2) ||
                      (state_q == PBM_WAITD) || (state_q == PBM_DATA);
    assign addr_ph  = (state_q == PBM_ADDR) || (state_q == PBM_ADDR2);
    assign drv_data = addr_ph || cur_q.write;

    // FRAME drops as the final phase starts, or one clock before IRDY on an early end.
    logic ending, frame_on;
    assign ending   = (state_q == PBM_WAITD && !devsel_s && tmo_q == 5'(DEVSEL_TO))
                      || (state_q == PBM_DATA && ((xfer && last_ph) || stop_s || !devsel_s
                          || tmo_q == 5'(TRDY_TO)));
    assign frame_on = addr_ph || ((state_q == PBM_WAITD || state_q == PBM_DATA) && !ending
                      && !last_ph && !(xfer && left_q == 8'h02));

    // Registered pin drive; parity lags its lane by one clock.
    always_ff @(posedge clk) begin
        if (rst) begin
            ad_o <= '0; ad_oe <= 1'b0; ad_hi_oe <= 1'b0;
            cbe_n_o <= 8'hff; cbe_oe <= 1'b0;
            frame_n_o <= 1'b1; req64_n_o <= 1'b1; irdy_n_o <= 1'b1; ctl_oe <= 1'b0;
            par_o <= 1'b0; par64_o <= 1'b0; par_oe <= 1'b0;
            lock_n_o <= 1'b1; lock_oe <= 1'b0;
        end else begin
            ad_o      <= {hi_ad, lo_ad};
            ad_oe     <= active && drv_data;
            ad_hi_oe  <= active && drv_data && cur_q.wide;
            cbe_n_o   <= {hi_cbe, lo_cbe};
            cbe_oe    <= active;
            frame_n_o <= !frame_on;
            req64_n_o <= !(frame_on && cur_q.wide);
            irdy_n_o  <= !(state_q == PBM_WAITD || (state_q == PBM_DATA && !(xfer && last_ph)));
            ctl_oe    <= active || state_q == PBM_TURN;
            par_o     <= par_lo;
            par64_o   <= par_hi;
            par_oe    <= ad_oe;
            lock_n_o  <= !(active && cur_q.locked);
            lock_oe   <= active || state_q == PBM_TURN;
        end
    end

    // Configuration select while a configuration address is out.
    always_ff @(posedge clk) begin
        if (rst) idsel_o <= 1'b0;
        else     idsel_o <= addr_ph && (cur_q.cmd[3:1] == 3'h5);
    end

    assign req_n = !(state_q == PBM_REQ || state_q == PBM_ADDR);

    // ------------------------------------------------------------------
    // Read data, status and side inputs
    // ------------------------------------------------------------------
    // Read words, error and end status.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0; rdata_valid <= 1'b0; status <= '0;
        end else begin
            rdata_valid <= xfer && !cur_q.write;
            if (xfer && !cur_q.write) begin
                rdata.data <= wide_q ? ad_i : {32'h0, ad_i[31:0]};
                rdata.be_n <= wdata.be_n;
            end
            status.done         <= (state_q == PBM_TURN);
            status.master_abort <= (state_q == PBM_WAITD) && !devsel_s
                                   && tmo_q == 5'(DEVSEL_TO);
            status.target_stop  <= (state_q == PBM_DATA) && stop_s;
            status.perr         <= active && perr_s && cur_q.cmd != PBM_CMD_SPCYC;
            status.serr         <= serr_s;
            status.got64        <= wide_q;
        end
    end

    // Snoop, interrupt and reset-strap status.
    always_ff @(posedge clk) begin
        if (rst) begin
            snoop_dirty <= 1'b0; snoop_clean <= 1'b0; irq_n_any <= 1'b1;
            strap_sh_q <= 3'b001; req64_strap <= 1'b0;
        end else begin
            snoop_dirty <= sdone_s && sbo_s;
            snoop_clean <= sdone_s && !sbo_s;
            irq_n_any   <= !(|int_s);
            strap_sh_q  <= {strap_sh_q[1:0], 1'b0};
            // Third clock: the first pin sample taken after reset has left the synchroniser.
            if (strap_sh_q[2]) req64_strap <= req64_s;
        end
    end

endmodule : pbm_master

// >>> verification/pbm_master_properties.sv
`timescale 1ns/1ps

// Bus-side timing and parity checks on the master's ports.
module pbm_master_properties
    import pbm_pkg::*;
#(
    parameter int DEVSEL_TO = PBM_DEVSEL_TO // Abort wait.
) (
    input wire logic        clk,        // Clock.
    input wire logic        rst,        // Reset.
    input wire logic        req_valid,  // Request.
    input wire logic        req_ready,  // Idle.
    input wire pbm_status_s status,     // Status.
    input wire logic        req_n,      // Bus request.
    input wire logic [63:0] ad_o,       // AD out.
    input wire logic        ad_oe,      // Low lane drive.
    input wire logic        ad_hi_oe,   // High lane drive.
    input wire logic [7:0]  cbe_n_o,    // Enables out.
    input wire logic        cbe_oe,     // Enables drive.
    input wire logic        par_o,      // PAR out.
    input wire logic        par64_o,    // PAR64 out.
    input wire logic        par_oe,     // Parity drive.
    input wire logic        frame_n_o,  // FRAME out.
    input wire logic        req64_n_o,  // REQ64 out.
    input wire logic        ctl_oe,     // Control drive.
    input wire logic        irdy_n_o,   // IRDY out.
    input wire logic        devsel_n_i, // DEVSEL in.
    input wire logic        stop_n_i    // STOP in.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    int   nosel_q;
    logic stop_q;

    // Cycles since the request was taken without any device select.
    always_ff @(posedge clk) begin
        nosel_q <= (rst || !devsel_n_i || (req_valid && req_ready)) ? 0 : nosel_q + 1;
    end

    // Remembers a target stop within the current transaction.
    always_ff @(posedge clk) begin
        stop_q <= (rst || (req_valid && req_ready)) ? 1'b0 : stop_q | !stop_n_i;
    end

    sequence s_addr;
        $fell(frame_n_o) && ctl_oe;
    endsequence
    sequence s_last;
        $rose(frame_n_o) && ctl_oe;
    endsequence

    a_reset_quiet: assert property ($fell(rst) |-> !ad_oe && !cbe_oe && !ctl_oe && req_n)
        else $error("bus driven after reset");
    a_idle_quiet: assert property (req_ready |-> req_n && frame_n_o)
        else $error("idle master requests bus");
    a_req64_start: assert property ($fell(req64_n_o) |-> s_addr)
        else $error("REQ64 not timed with FRAME");
    a_irdy_follow: assert property (s_addr |-> ##[1:2] !irdy_n_o)
        else $error("no data phase after address");
    a_last_irdy: assert property (s_last |-> !irdy_n_o)
        else $error("FRAME released without IRDY");
    a_par_even: assert property (par_oe && $past(ad_oe) && $past(cbe_oe)
        |-> par_o == ^{$past(ad_o[31:0]), $past(cbe_n_o[3:0])}) else $error("PAR wrong");
    a_par64_even: assert property (par_oe && $past(ad_hi_oe) && $past(cbe_oe)
        |-> par64_o == ^{$past(ad_o[63:32]), $past(cbe_n_o[7:4])}) else $error("PAR64 wrong");
    a_abort_wait: assert property (status.master_abort |-> nosel_q >= DEVSEL_TO)
        else $error("abort too early");
    a_stop_cause: assert property (status.target_stop |-> stop_q)
        else $error("stop status without STOP");
endmodule : pbm_master_properties

bind pbm_master pbm_master_properties #(.DEVSEL_TO(DEVSEL_TO)) u_props (.clk, .rst,
    .req_valid, .req_ready, .status, .req_n, .ad_o, .ad_oe, .ad_hi_oe, .cbe_n_o, .cbe_oe,
    .par_o, .par64_o, .par_oe, .frame_n_o, .req64_n_o, .ctl_oe, .irdy_n_o, .devsel_n_i,
    .stop_n_i);

// >>> verification/pbm_target_model.sv
`timescale 1ns/1ps

// Arbiter and address-pattern target on the far side of the bus.
module pbm_target_model
    import pbm_pkg::*;
(
    input  wire logic        clk,       // Clock.
    input  wire logic        rst,       // Reset.
    input  wire logic        req_n,     // Bus request.
    input  wire logic        ctl_oe,    // Control drive.
    input  wire logic        frame_n_o, // FRAME.
    input  wire logic        irdy_n_o,  // IRDY.
    input  wire logic        req64_n_o, // REQ64.
    input  wire logic [63:0] ad_o,      // AD from master.
    input  wire logic [7:0]  cbe_n_o,   // Enables.
    input  wire logic        idsel_o,   // Config select.
    input  wire logic        no_sel,    // Never claim.
    input  wire logic        slow,      // Pace TRDY.
    input  wire logic        do_stop,   // Raise STOP.
    input  wire logic [1:0]  err,       // Raise PERR, SERR.
    output logic             gnt_n,     // Grant.
    output logic             devsel_n,  // DEVSEL.
    output logic             ack64_n,   // ACK64.
    output logic             trdy_n,    // TRDY.
    output logic             stop_n,    // STOP.
    output logic             perr_n,    // PERR.
    output logic             serr_n,    // SERR.
    output logic [63:0]      tad,       // AD from target.
    output logic             tpar,      // PAR from target.
    output logic             tpar64     // PAR64 from target.
);
    logic        fq, wr, cfg, w64, idq;
    logic [63:0] pat;
    wire         act   = ctl_oe && (!frame_n_o || !irdy_n_o);
    wire         start = ctl_oe && !frame_n_o && fq;
    // A dual address cycle carries the real command on the upper enables.
    wire [3:0]   cmd_a = (cbe_n_o[3:0] == PBM_CMD_DAC) ? cbe_n_o[7:4] : cbe_n_o[3:0];

    // Grant follows the dedicated request line.
    always_ff @(posedge clk) gnt_n <= rst | req_n;

    // Decode command, width and read pattern in the address phase.
    always_ff @(posedge clk) begin
        fq  <= frame_n_o || !ctl_oe;
        idq <= start ? idsel_o : idq | idsel_o;
        if (start) begin
            wr  <= cmd_a[0];
            cfg <= cmd_a[3:1] == 3'b101;
            w64 <= !req64_n_o;
            pat <= {~ad_o[31:0], ad_o[31:0]};
        end
    end

    // Claim after decode; ACK64 timed with DEVSEL; TRDY paced when slow.
    always_ff @(posedge clk) begin
        if (rst || !act) begin
            {devsel_n, ack64_n, trdy_n, stop_n, perr_n, serr_n} <= 6'h3f;
        end else if (!no_sel && !start && (!cfg || idq)) begin
            devsel_n <= 1'b0;
            ack64_n  <= !w64;
            trdy_n   <= slow ? !trdy_n : 1'b0;
            stop_n   <= !do_stop;
            perr_n   <= !err[0];
            serr_n   <= !err[1];
        end
    end

    // Read data with the TRDY claim, inverted when released; parity a cycle later.
    always_ff @(posedge clk) begin
        tad    <= rst ? 64'h0 : (act && !wr && !start) ? pat : ~tad;
        tpar   <= ^{tad[31:0], cbe_n_o[3:0]};
        tpar64 <= ^{tad[63:32], cbe_n_o[7:4]};
    end
endmodule : pbm_target_model

// >>> verification/test_pbm_master.sv
`timescale 1ns/1ps

// Random and corner transactions against the master with a target model.
module test_pbm_master;
    import pbm_pkg::*;
    logic clk = 1'b0;
    logic lk, lks, lock_n_o, lock_oe;
    logic rst, req_valid, req_ready, wdata_ready, rdata_valid, irq_n_any, req_n, gnt_n;
    logic snoop_dirty, snoop_clean, req64_strap, ad_oe, ad_hi_oe, cbe_oe, par_o, par64_o;
    logic par_oe, frame_n_o, req64_n_o, ctl_oe, irdy_n_o, devsel_n, ack64_n, trdy_n, stop_n;
    logic perr_n, serr_n, sdone, sbo_n, idsel_o, tpar, tpar64, strap_n, no_sel, slow, do_stop;
    logic [63:0] ad_o, tad;
    logic [7:0]  cbe_n_o;
    logic [3:0]  int_n, c;
    logic [1:0]  err;
    pbm_req_s    req;
    pbm_word_s   wdata, rdata;
    pbm_status_s status, st;
    int          mismatches, compares, n, i, l;
    logic [3:0]  cmds [4] = '{4'h6, 4'h7, 4'ha, 4'hb};

    pbm_master dut_u (.clk, .rst, .req_valid, .req_ready, .req, .wdata, .wdata_ready, .rdata,
        .rdata_valid, .status, .irq_n_any, .snoop_dirty, .snoop_clean, .req64_strap, .req_n,
        .gnt_n, .ad_i({ad_hi_oe ? ad_o[63:32] : tad[63:32], ad_oe ? ad_o[31:0] : tad[31:0]}),
        .ad_o, .ad_oe, .ad_hi_oe, .cbe_n_o, .cbe_oe, .par_i(par_oe ? par_o : tpar),
        .par64_i(par_oe ? par64_o : tpar64), .par_o, .par64_o, .par_oe, .frame_n_o,
        .req64_n_o, .ctl_oe, .irdy_n_o, .lock_n_o, .lock_oe,
        .req64_n_i(ctl_oe ? req64_n_o : strap_n), .devsel_n_i(devsel_n), .ack64_n_i(ack64_n),
        .trdy_n_i(trdy_n), .stop_n_i(stop_n), .perr_n_i(perr_n), .serr_n_i(serr_n),
        .int_n_i(int_n), .sdone_i(sdone), .sbo_n_i(sbo_n), .idsel_o);
    pbm_target_model tgt_u (.clk, .rst, .req_n, .ctl_oe, .frame_n_o, .irdy_n_o, .req64_n_o,
        .ad_o, .cbe_n_o, .idsel_o, .no_sel, .slow, .do_stop, .err, .gnt_n, .devsel_n,
        .ack64_n, .trdy_n, .stop_n, .perr_n, .serr_n, .tad, .tpar, .tpar64);

    // Bus clock at 40 MHz.
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic fail(input string m);
        mismatches++;
        $display("ERROR %0t %s", $time, m);
    endtask : fail
    task automatic chk(input logic g, input logic e);
        compares++;
        if (g !== e) fail("flag mismatch");
    endtask : chk
    task automatic chkw(input logic [63:0] g, input logic [63:0] e);
        compares++;
        if (g !== e) fail("read word mismatch");
    endtask : chkw
    task automatic chkn(input int g, input int e);
        compares++;
        if (g != e) fail("word count mismatch");
    endtask : chkn

    task automatic results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // One transaction; reads checked against the target's address pattern.
    task automatic run(input logic w, wd, dac, input logic [3:0] cm, input logic [7:0] ln);
        logic [63:0] a, m;
        logic        pw;
        int          k;
        a = {$urandom, $urandom};
        if (!dac) a[63:32] = 32'h0;
        m = wd ? '1 : 64'h0000_0000_ffff_ffff;
        st = '0;
        n = 0;
        pw = 1'b0;
        lks = 1'b0;
        while (req_ready !== 1'b1) @(negedge clk);
        req = '{w, wd, dac, lk, cm, a, ln};
        wdata = '{{$urandom, $urandom}, 8'($urandom)};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        for (k = 0; k < 400 && !st.done && !st.master_abort; k++) begin
            @(negedge clk);
            if (pw) wdata = '{{$urandom, $urandom}, 8'($urandom)};
            pw = wdata_ready;
            n += int'(wdata_ready) + int'(rdata_valid);
            if (rdata_valid) chkw(rdata.data & m, {~a[31:0], a[31:0]} & m);
            st = pbm_status_s'(st | status);
            lks = lks | (!lock_n_o && lock_oe);
        end
        repeat (6) begin
            @(negedge clk);
            st = pbm_status_s'(st | status);
        end
        // Width is a level of the finished transaction, not of the one before it.
        st.got64 = status.got64;
    endtask : run

    initial begin
        #1000000;
        fail("watchdog expired");
        results();
    end

    initial begin
        {mismatches, compares} = '0;
        {rst, strap_n, int_n, sbo_n} = '1;
        {req_valid, sdone, no_sel, slow, do_stop, err, lk} = '0;
        req = '0;
        wdata = '0;
        strap_n = 1'b0;
        void'($urandom(32'h1680));
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(req_n, 1'b1);
        chk(ctl_oe, 1'b0);
        repeat (3) @(negedge clk);
        chk(req64_strap, 1'b1);
        strap_n = 1'b1;
        $display("reset test done");
        for (i = 0; i < 12; i++) begin
            c = cmds[i % 4];
            l = 1 + $urandom % 4;
            slow = i[2];
            run(c[0], i[0] ^ i[1], 1'b0, c, l[7:0]);
            chk(st.done, 1'b1);
            chkn(n, l);
            chk(st.got64, i[0] ^ i[1]);
            chk(lks, 1'b0);
        end
        run(1'b1, 1'b0, 1'b0, 4'h7, 8'h00);
        chkn(n, 1);
        run(1'b0, 1'b1, 1'b1, 4'h6, 8'h02);
        chkn(n, 2);
        $display("transfer test done");
        no_sel = 1'b1;
        run(1'b0, 1'b0, 1'b0, 4'h6, 8'h01);
        chk(st.master_abort, 1'b1);
        no_sel = 1'b0;
        do_stop = 1'b1;
        run(1'b0, 1'b1, 1'b0, 4'h6, 8'h04);
        chk(st.target_stop, 1'b1);
        do_stop = 1'b0;
        err = 2'b01;
        run(1'b1, 1'b0, 1'b0, 4'h7, 8'h02);
        chk(st.perr, 1'b1);
        err = 2'b10;
        run(1'b0, 1'b0, 1'b0, 4'h6, 8'h01);
        chk(st.serr, 1'b1);
        err = 2'b00;
        lk = 1'b1;
        run(1'b0, 1'b0, 1'b0, 4'h6, 8'h02);
        chk(lks, 1'b1);
        chkn(n, 2);
        lk = 1'b0;
        $display("termination test done");
        for (i = 0; i < 8; i++) begin
            {int_n, sdone, sbo_n} = 6'($urandom);
            repeat (4) @(negedge clk);
            chk(irq_n_any, &int_n);
            chk(snoop_dirty, sdone & !sbo_n);
            chk(snoop_clean, sdone & sbo_n);
        end
        $display("side signal test done");
        results();
    end
endmodule : test_pbm_master
